//--- common/lpm_pkg.sv
// shared constants, register layouts and lookups for the lcd mode block
package lpm_pkg;
	// serial word layout: address in the top three bits, data below
	localparam int          WORD_BITS  = 16;
	localparam logic [4:0]  WORD_COUNT = 5'h10;
	localparam logic [4:0]  COUNT_SAT  = 5'h1F;
	localparam logic [2:0]  ADDR_LEVEL_POL = 3'h4;
	localparam logic [2:0]  ADDR_FORMAT    = 3'h5;
	localparam logic [2:0]  ADDR_POWER     = 3'h6;

	// field positions follow the packed order, d0 in the lsb
	typedef struct packed {
		logic       invert;
		logic [2:0] level;
	} lpm_level_pol_t;
	typedef struct packed {
		logic sync_neg;
		logic wide;
		logic pal;
		logic auto_fmt;
	} lpm_format_t;
	typedef struct packed {
		logic [2:0] cpl_sel;
		logic       pll_off;
		logic       pwm_on;
	} lpm_power_t;

	localparam logic [3:0] LEVEL_POL_RST = 4'h6;
	localparam logic [3:0] FORMAT_RST    = 4'h1;
	localparam logic [4:0] POWER_RST     = 5'h10;

	// video geometry
	localparam logic [9:0] PAL_LINE_MIN  = 10'h120;
	localparam logic [7:0] LINES_INPUT   = 8'hF0;
	localparam logic [7:0] LINES_SHOWN   = 8'hB4;
	localparam logic [5:0] BLACK_LINES   = 6'h3C;
	localparam logic [4:0] BAND_LINES    = 5'h1E;
	localparam logic [4:0] GATE_GROUP    = 5'h0F;
	localparam logic [1:0] DROP_PHASE    = 2'h3;
	localparam logic [1:0] GROUPS_PER_BAND = 2'(BAND_LINES / GATE_GROUP);

	// boost pwm: 10 of 12 slots is the 83 percent ceiling
	localparam logic [2:0] DEBOUNCE_CYCLES = 3'h4;
	localparam logic [3:0] PWM_SLOTS       = 4'hC;
	localparam logic [3:0] DUTY_MAX        = 4'hA;

	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'b00,
		SEQ_TOP     = 2'b01,
		SEQ_PICTURE = 2'b10,
		SEQ_BOTTOM  = 2'b11
	} lpm_seq_t;
	typedef enum logic [1:0] {
		PWM_OFF   = 2'b00,
		PWM_RAISE = 2'b01,
		PWM_LOWER = 2'b10
	} lpm_pwm_t;

	function automatic logic [9:0] lpm_cpl(input logic [2:0] sel);
		case (sel)
			3'h0:    lpm_cpl = 10'h262;
			3'h1:    lpm_cpl = 10'h264;
			3'h2:    lpm_cpl = 10'h266;
			3'h3:    lpm_cpl = 10'h268;
			3'h4:    lpm_cpl = 10'h252;
			3'h5:    lpm_cpl = 10'h255;
			3'h6:    lpm_cpl = 10'h256;
			default: lpm_cpl = 10'h258;
		endcase
	endfunction
endpackage

//--- dv/lpm_host_model.sv
// host model driving the three-wire configuration port
`timescale 1ns/10ps
module lpm_host_model (
	// clock
	input  wire logic clk,
	// serial port
	output logic      serial_clk,
	output logic      serial_data,
	output logic      serial_cs_n
);
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		serial_cs_n = 1'b1;
	end

	task automatic hold2();
		repeat (2) @(posedge clk);
		#2;
	endtask

	// every serial_clk level lasts two clocks, double the one-clock minimum
	task automatic send(input logic [2:0] a, input logic [12:0] d);
		logic [15:0] w;
		w = {a, d};
		@(posedge clk);
		#2;
		serial_cs_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			serial_data = w[i];
			hold2();
			serial_clk = 1'b1;
			hold2();
			serial_clk = 1'b0;
		end
		hold2();
		serial_cs_n = 1'b1;
		// released line shows the inverse so a stale bit cannot help
		serial_data = ~w[0];
		hold2();
		hold2();
	endtask

	// ntsc rate 594 or pal rate 616, low bits carry pll and pwm
	task automatic set_rate(input logic pal, input logic [1:0] low);
		send(3'h6, {8'h00, pal ? 3'h3 : 3'h4, low});
	endtask
endmodule

//--- dv/lpm_mode_config_bench.sv
// self-checking bench for the lcd mode configuration block
`timescale 1ns/10ps
module lpm_mode_config_bench;
	logic       clk = 1'b0;
	logic       reset_n;
	logic       hsync_in = 1'b0;
	logic       vsync_in = 1'b0;
	logic       feedback_comparator_out = 1'b0;
	logic       act = 1'b1;
	wire logic  sck, sdo, scs_n;
	logic [2:0] level;
	logic       frame_pol, com_pol, pal, wide, pll_en;
	logic [9:0] cpl;
	logic       grp_p, blk_p, show_p, drop_p, drive;
	int         error_cnt = 0;
	int         n_tests = 0;
	int         n_grp, n_shw, n_drp;

	always #25 clk = ~clk;

	lpm_host_model u_lpm_host_model (
		.clk         (clk),
		.serial_clk  (sck),
		.serial_data (sdo),
		.serial_cs_n (scs_n)
	);

	lpm_mode_config u_lpm_mode_config (
		.clk                        (clk),
		.reset_n                    (reset_n),
		.serial_clk                 (sck),
		.serial_data                (sdo),
		.serial_cs_n                (scs_n),
		.hsync_in                   (hsync_in),
		.vsync_in                   (vsync_in),
		.feedback_comparator_out    (feedback_comparator_out),
		.common_ac_level            (level),
		.digital_frame_polarity_out (frame_pol),
		.panel_common_polarity_out  (com_pol),
		.video_is_pal               (pal),
		.wide_mode                  (wide),
		.pll_enable                 (pll_en),
		.pll_clocks_per_line        (cpl),
		.gate_group_pulse           (grp_p),
		.black_fill                 (blk_p),
		.line_show                  (show_p),
		.line_drop                  (drop_p),
		.boost_gate_drive           (drive)
	);

	always @(posedge clk) begin
		n_grp += int'(grp_p & blk_p);
		n_shw += int'(show_p);
		n_drp += int'(drop_p);
	end

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
			input logic [15:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [2:0] a, input logic [12:0] d);
		u_lpm_host_model.send(a, d);
	endtask

	task automatic vs();
		vsync_in = act;
		step(2);
		vsync_in = ~act;
		step(3);
	endtask

	task automatic hs(input int n);
		repeat (n) begin
			hsync_in = act;
			step(2);
			hsync_in = ~act;
			step(2);
		end
	endtask

	task automatic t_reset();
		chk("level", 3'h6, level);
		chk("cpl", 10'h252, cpl);
		chk("pll_en", 1'h1, pll_en);
		chk("wide", 1'h0, wide);
		chk("pal", 1'h0, pal);
		chk("drive", 1'h0, drive);
		$display("test reset done");
	endtask

	task automatic t_level_pol();
		wr(3'h4, 13'h000B);
		chk("level", 3'h6, level);
		vs();
		chk("level", 3'h3, level);
		chk("frame_pol", 1'h0, frame_pol);
		chk("com_pol", 1'h1, com_pol);
		hs(1);
		chk("com_pol", 1'h0, com_pol);
		wr(3'h4, 13'h0002);
		vs();
		chk("com_pol", 1'h0, com_pol);
		chk("level", 3'h2, level);
		$display("test level and polarity done");
	endtask

	task automatic t_cpl();
		logic [9:0] t [8];
		t = '{10'h262, 10'h264, 10'h266, 10'h268,
			10'h252, 10'h255, 10'h256, 10'h258};
		for (int i = 0; i < 8; i++) begin
			wr(3'h6, {8'h00, 3'(i), i[0], 1'b0});
			vs();
			chk("cpl", t[i], cpl);
			chk("pll_en", 16'(!i[0]), pll_en);
		end
		$display("test clocks per line done");
	endtask

	task automatic t_format();
		u_lpm_host_model.set_rate(1'b1, 2'h0);
		wr(3'h5, 13'h0002);
		vs();
		chk("pal", 1'h1, pal);
		chk("cpl", 10'h268, cpl);
		wr(3'h5, 13'h0001);
		vs();
		hs(290);
		vs();
		chk("pal", 1'h1, pal);
		hs(10);
		vs();
		chk("pal", 1'h0, pal);
		$display("test format done");
	endtask

	task automatic t_wide();
		wr(3'h5, 13'h0004);
		vs();
		chk("wide", 1'h1, wide);
		n_grp = 0;
		n_shw = 0;
		n_drp = 0;
		hs(2);
		chk("groups", 16'h0002, 16'(n_grp));
		chk("shown", 16'h0000, 16'(n_shw));
		hs(240);
		chk("shown", 16'h00B4, 16'(n_shw));
		chk("dropped", 16'h003C, 16'(n_drp));
		hs(6);
		chk("groups", 16'h0004, 16'(n_grp));
		chk("shown", 16'h00B4, 16'(n_shw));
		$display("test wide done");
	endtask

	task automatic duty(output logic [3:0] n);
		n = 4'h0;
		repeat (12) begin
			step(1);
			n += {3'h0, drive};
		end
	endtask

	task automatic t_pwm();
		logic [3:0] n;
		wr(3'h6, 13'h0011);
		vs();
		// low, high, low: full climb and full descent each time
		for (int k = 0; k < 3; k++) begin
			feedback_comparator_out = k[0];
			step(180);
			duty(n);
			chk("duty", k[0] ? 4'h0 : 4'hA, n);
		end
		wr(3'h6, 13'h0010);
		vs();
		duty(n);
		chk("duty", 4'h0, n);
		$display("test pwm done");
	endtask

	task automatic t_sync();
		wr(3'h5, 13'h0008);
		vs();
		act = 1'b0;
		hsync_in = 1'b1;
		vsync_in = 1'b1;
		step(4);
		vs();
		chk("frame_pol", 1'h0, frame_pol);
		// negative syncs: the line must start on the falling level
		hsync_in = 1'b0;
		step(2);
		chk("frame_pol", 1'h1, frame_pol);
		hsync_in = 1'b1;
		step(2);
		hs(1);
		chk("frame_pol", 1'h0, frame_pol);
		$display("test sync polarity done");
	endtask

	task automatic conclude();
		$display("tests %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		// driven at time zero so the asynchronous reset sees an edge
		reset_n = 1'b0;
		step(12);
		reset_n = 1'b1;
		step(3);
		t_reset();
		t_level_pol();
		t_cpl();
		t_format();
		t_wide();
		t_pwm();
		t_sync();
		conclude();
	end

	// about five times the expected run length
	initial begin
		#1000000;
		error_cnt++;
		conclude();
	end
endmodule

//--- rtl/lpm_debounce.sv
// comparator debounce: output follows only a level held for several cycles
`timescale 1ns/10ps
module lpm_debounce (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// signal
	input  wire logic raw,
	output logic      clean
);
	logic       clean_r;
	logic [2:0] cnt_r;

	wire differs = raw != clean_r;
	wire settle  = differs && (cnt_r == lpm_pkg::DEBOUNCE_CYCLES - 3'h1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			clean_r <= 1'b0;
			cnt_r   <= 3'h0;
		end else begin
			cnt_r   <= (differs && !settle) ? cnt_r + 3'h1 : 3'h0;
			if (settle)
				clean_r <= raw;
		end
	end

	assign clean = clean_r;
endmodule

//--- rtl/lpm_mode_config.sv
// lcd mode configuration: serial registers, sync, wide sequencing, boost pwm
`timescale 1ns/10ps
// Function
// RQ1: three-bit common level code, eight 0.2 V steps, reset code 110.
// RQ2: common polarity follows frame polarity, inverted when invert bit set.
// RQ3: without inversion the common polarity is negative on a frame's first line.
// RQ4: format bit d0 high selects automatic format detection, default high.
// RQ5: manual format: d1 low is NTSC, high is PAL.
// RQ6: format bit d2 high selects 16:9 wide display, default normal.
// RQ7: format bit d3 low means positive syncs, high means negative.
// RQ8: control bit d0 high runs the pwm circuit, low holds it shut.
// RQ9: control bit d1 high stops internal pixel clock, outside supplies it.
// RQ10: control bits d4..d2 choose clocks per line, default code 100.
// RQ11: pixel clock equals clocks per line times the line rate.
// RQ12: host should program 594 for NTSC and 616 for PAL.
// RQ13: wide mode drops one line of four, 240 input lines become 180.
// RQ14: wide mode writes 60 black lines, half above and half below.
// RQ15: black bands use grouped gate pulses of fifteen rows each.
// RQ16: bottom band after 180 lines uses the same grouped method.
// RQ17: comparator output is debounced before the pwm machine uses it.
// RQ18: pwm machine steps duty in discrete steps from debounced comparator.
// RQ19: comparator low raises duty stepwise from zero, never above 83 percent.
// RQ20: comparator high lowers duty stepwise toward zero.
// RQ21: register writes take effect at the next frame boundary.
module lpm_mode_config (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// serial configuration port
	input  wire logic       serial_clk,
	input  wire logic       serial_data,
	input  wire logic       serial_cs_n,
	// video sync inputs
	input  wire logic       hsync_in,
	input  wire logic       vsync_in,
	// boost feedback
	input  wire logic       feedback_comparator_out,
	// panel polarity and level
	output logic [2:0]      common_ac_level,
	output logic            digital_frame_polarity_out,
	output logic            panel_common_polarity_out,
	// format status
	output logic            video_is_pal,
	output logic            wide_mode,
	// pixel clock pll control
	output logic            pll_enable,
	output logic [9:0]      pll_clocks_per_line,
	// gate and line control
	output logic            gate_group_pulse,
	output logic            black_fill,
	output logic            line_show,
	output logic            line_drop,
	// boost converter
	output logic            boost_gate_drive
);
	logic [1:0] rst_pipe_r;
	wire        rst_n = rst_pipe_r[1];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rst_pipe_r <= 2'b00;
		else
			rst_pipe_r <= {rst_pipe_r[0], 1'b1};
	end

	// serial writes land in pending copies
	logic        wr_stb;
	logic [2:0]  wr_addr;
	logic [12:0] wr_data;

	lpm_serial_rx u_rx (
		.clk     (clk),
		.rst_n   (rst_n),
		.scl     (serial_clk),
		.sda     (serial_data),
		.cs_n    (serial_cs_n),
		.wr_stb  (wr_stb),
		.wr_addr (wr_addr),
		.wr_data (wr_data)
	);

	lpm_pkg::lpm_level_pol_t pend_lvl_r, act_lvl_r, act_lvl_nxt;
	lpm_pkg::lpm_format_t    pend_fmt_r, act_fmt_r;
	lpm_pkg::lpm_power_t     pend_pwr_r, act_pwr_r;

	wire wr_lvl = wr_stb && wr_addr == lpm_pkg::ADDR_LEVEL_POL;
	wire wr_fmt = wr_stb && wr_addr == lpm_pkg::ADDR_FORMAT;
	wire wr_pwr = wr_stb && wr_addr == lpm_pkg::ADDR_POWER;

	// sync normalisation and edge detection
	logic hs_q_r;
	logic vs_q_r;
	wire  hs_norm   = hsync_in ^ act_fmt_r.sync_neg; // RQ7
	wire  vs_norm   = vsync_in ^ act_fmt_r.sync_neg; // RQ7
	wire  hsync_evt = hs_norm && !hs_q_r;
	wire  vsync_evt = vs_norm && !vs_q_r;

	// a write in the boundary cycle itself waits for the next frame
	assign act_lvl_nxt = vsync_evt ? pend_lvl_r : act_lvl_r; // RQ21

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_lvl_r <= lpm_pkg::LEVEL_POL_RST; // RQ1
			pend_fmt_r <= lpm_pkg::FORMAT_RST;
			pend_pwr_r <= lpm_pkg::POWER_RST;
			act_lvl_r  <= lpm_pkg::LEVEL_POL_RST;
			act_fmt_r  <= lpm_pkg::FORMAT_RST;
			act_pwr_r  <= lpm_pkg::POWER_RST;
			hs_q_r     <= 1'b0;
			vs_q_r     <= 1'b0;
		end else begin
			if (wr_lvl)
				pend_lvl_r <= wr_data[3:0];
			if (wr_fmt)
				pend_fmt_r <= wr_data[3:0];
			if (wr_pwr)
				pend_pwr_r <= wr_data[4:0];
			act_lvl_r <= act_lvl_nxt; // RQ21
			if (vsync_evt) begin
				act_fmt_r <= pend_fmt_r; // RQ21
				act_pwr_r <= pend_pwr_r; // RQ21
			end
			hs_q_r <= hs_norm;
			vs_q_r <= vs_norm;
		end
	end

	// frame polarity, line counting and format detection
	// reset count folded to a constant so the reset branch stays plain
	localparam logic [9:0] CPL_RST =
		lpm_pkg::lpm_cpl(lpm_pkg::POWER_RST[4:2]);

	logic       frame_pol_r;
	logic       com_pol_r;
	logic [9:0] line_cnt_r;
	logic       pal_r;
	logic [9:0] cpl_r;

	wire frame_pol_nxt = vsync_evt ? 1'b0
		: (hsync_evt ? !frame_pol_r : frame_pol_r); // RQ3
	wire line_pal = line_cnt_r >= lpm_pkg::PAL_LINE_MIN;
	wire pal_nxt  = pend_fmt_r.auto_fmt ? line_pal : pend_fmt_r.pal; // RQ4 RQ5

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_pol_r <= 1'b0;
			com_pol_r   <= 1'b0;
			line_cnt_r  <= 10'h000;
			pal_r       <= 1'b0;
			cpl_r       <= CPL_RST;
		end else begin
			frame_pol_r <= frame_pol_nxt;
			com_pol_r   <= frame_pol_nxt ^ act_lvl_nxt.invert; // RQ2
			if (vsync_evt) begin
				line_cnt_r <= 10'h000;
				pal_r      <= pal_nxt; // RQ4
				cpl_r      <= lpm_pkg::lpm_cpl(pend_pwr_r.cpl_sel); // RQ10
			end else if (hsync_evt && line_cnt_r != 10'h3FF) begin
				line_cnt_r <= line_cnt_r + 10'h001;
			end
		end
	end

	// the analog pll multiplies the line rate by this count
	assign pll_clocks_per_line = cpl_r; // RQ11
	assign pll_enable          = !act_pwr_r.pll_off; // RQ9
	assign common_ac_level     = act_lvl_r.level; // RQ1
	assign digital_frame_polarity_out = frame_pol_r;
	assign panel_common_polarity_out  = com_pol_r;
	assign video_is_pal        = pal_r;
	assign wide_mode           = act_fmt_r.wide; // RQ6

	// wide-mode line sequencer
	lpm_pkg::lpm_seq_t seq_r;
	logic [1:0]        grp_r;
	logic [7:0]        in_cnt_r;
	logic              gate_r;
	logic              black_r;
	logic              show_r;
	logic              drop_r;

	wire last_grp  = grp_r == lpm_pkg::GROUPS_PER_BAND - 2'h1;
	wire last_in   = in_cnt_r == lpm_pkg::LINES_INPUT - 8'h01;
	wire drop_this = in_cnt_r[1:0] == lpm_pkg::DROP_PHASE; // RQ13
	wire in_band   = seq_r == lpm_pkg::SEQ_TOP || seq_r == lpm_pkg::SEQ_BOTTOM;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_r    <= lpm_pkg::SEQ_IDLE;
			grp_r    <= 2'h0;
			in_cnt_r <= 8'h00;
			gate_r   <= 1'b0;
			black_r  <= 1'b0;
			show_r   <= 1'b0;
			drop_r   <= 1'b0;
		end else begin
			gate_r  <= 1'b0;
			black_r <= 1'b0;
			show_r  <= 1'b0;
			drop_r  <= 1'b0;
			if (vsync_evt) begin
				seq_r    <= pend_fmt_r.wide ? lpm_pkg::SEQ_TOP
					: lpm_pkg::SEQ_IDLE; // RQ6
				grp_r    <= 2'h0;
				in_cnt_r <= 8'h00;
			end else if (hsync_evt) begin
				case (seq_r)
					lpm_pkg::SEQ_TOP, lpm_pkg::SEQ_BOTTOM: begin
						gate_r  <= 1'b1; // RQ15
						black_r <= 1'b1; // RQ14
						grp_r   <= last_grp ? 2'h0 : grp_r + 2'h1;
						if (last_grp)
							seq_r <= (seq_r == lpm_pkg::SEQ_TOP)
								? lpm_pkg::SEQ_PICTURE
								: lpm_pkg::SEQ_IDLE; // RQ16
					end
					lpm_pkg::SEQ_PICTURE: begin
						show_r   <= !drop_this; // RQ13
						drop_r   <= drop_this; // RQ13
						in_cnt_r <= in_cnt_r + 8'h01;
						if (last_in)
							seq_r <= lpm_pkg::SEQ_BOTTOM; // RQ16
					end
					default:
						show_r <= !act_fmt_r.wide;
				endcase
			end
		end
	end

	assign gate_group_pulse = gate_r;
	assign black_fill       = black_r;
	assign line_show        = show_r;
	assign line_drop        = drop_r;

	// boost pwm state machine
	logic fb_clean;

	lpm_debounce u_deb (
		.clk   (clk),
		.rst_n (rst_n),
		.raw   (feedback_comparator_out),
		.clean (fb_clean)
	); // RQ17

	lpm_pkg::lpm_pwm_t pwm_r;
	logic [3:0]        slot_r;
	logic [3:0]        duty_r;
	logic              drive_r;

	wire period_end = slot_r == lpm_pkg::PWM_SLOTS - 4'h1;
	wire at_max     = duty_r == lpm_pkg::DUTY_MAX;
	wire at_zero    = duty_r == 4'h0;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_r   <= lpm_pkg::PWM_OFF;
			slot_r  <= 4'h0;
			duty_r  <= 4'h0;
			drive_r <= 1'b0;
		end else begin
			drive_r <= act_pwr_r.pwm_on && pwm_r != lpm_pkg::PWM_OFF
				&& slot_r < duty_r; // RQ8
			if (!act_pwr_r.pwm_on) begin
				pwm_r  <= lpm_pkg::PWM_OFF; // RQ8
				slot_r <= 4'h0;
				duty_r <= 4'h0;
			end else begin
				slot_r <= period_end ? 4'h0 : slot_r + 4'h1;
				// duty only moves on period edges so a pulse is never cut
				case (pwm_r)
					lpm_pkg::PWM_RAISE:
						if (period_end && !at_max)
							duty_r <= duty_r + 4'h1; // RQ19
					lpm_pkg::PWM_LOWER:
						if (period_end && !at_zero)
							duty_r <= duty_r - 4'h1; // RQ20
					default:
						duty_r <= 4'h0;
				endcase
				pwm_r <= fb_clean ? lpm_pkg::PWM_LOWER
					: lpm_pkg::PWM_RAISE; // RQ18
			end
		end
	end

	assign boost_gate_drive = drive_r;

	property p_level_load;
		@(posedge clk) disable iff (!rst_n)
		vsync_evt |=> common_ac_level == $past(pend_lvl_r.level);
	endproperty
	a_level_load: assert property (p_level_load) // RQ1
		else $error("common level not loaded at frame start");

	property p_common_pol;
		@(posedge clk) disable iff (!rst_n)
		panel_common_polarity_out ==
			(digital_frame_polarity_out ^ act_lvl_r.invert);
	endproperty
	a_common_pol: assert property (p_common_pol) // RQ2
		else $error("common polarity does not track frame polarity");

	property p_first_line_neg;
		@(posedge clk) disable iff (!rst_n)
		vsync_evt |=> !digital_frame_polarity_out
			&& (panel_common_polarity_out == act_lvl_r.invert);
	endproperty
	a_first_line_neg: assert property (p_first_line_neg) // RQ3
		else $error("first line polarity not negative");

	property p_manual_fmt;
		@(posedge clk) disable iff (!rst_n)
		vsync_evt && !pend_fmt_r.auto_fmt
			|=> video_is_pal == $past(pend_fmt_r.pal);
	endproperty
	a_manual_fmt: assert property (p_manual_fmt) // RQ5
		else $error("manual format not applied");

	property p_pwm_off;
		@(posedge clk) disable iff (!rst_n)
		!act_pwr_r.pwm_on |=> !boost_gate_drive;
	endproperty
	a_pwm_off: assert property (p_pwm_off) // RQ8
		else $error("boost drive while pwm shut down");

	property p_cpl;
		@(posedge clk) disable iff (!rst_n)
		vsync_evt && pend_pwr_r.cpl_sel == 3'h4
			|=> pll_clocks_per_line == 10'h252;
	endproperty
	a_cpl: assert property (p_cpl) // RQ10
		else $error("clocks per line mismatch");

	property p_drop;
		@(posedge clk) disable iff (!rst_n)
		hsync_evt && seq_r == lpm_pkg::SEQ_PICTURE && !vsync_evt
			|=> line_drop == $past(in_cnt_r[1:0] == 2'h3) && !black_fill;
	endproperty
	a_drop: assert property (p_drop) // RQ13
		else $error("wrong line dropped");

	property p_group_black;
		@(posedge clk) disable iff (!rst_n)
		gate_group_pulse |-> black_fill && !line_show && $past(in_band);
	endproperty
	a_group_black: assert property (p_group_black) // RQ15
		else $error("grouped gate pulse outside black band");

	property p_duty_max;
		@(posedge clk) disable iff (!rst_n)
		duty_r <= lpm_pkg::DUTY_MAX;
	endproperty
	a_duty_max: assert property (p_duty_max) // RQ19
		else $error("duty above ceiling");

	property p_duty_down;
		@(posedge clk) disable iff (!rst_n)
		act_pwr_r.pwm_on && pwm_r == lpm_pkg::PWM_LOWER && period_end
			&& !at_zero |=> duty_r == $past(duty_r) - 4'h1;
	endproperty
	a_duty_down: assert property (p_duty_down) // RQ20
		else $error("duty did not step down");

	property p_frame_apply;
		@(posedge clk) disable iff (!rst_n)
		$changed(act_fmt_r) || $changed(act_pwr_r) |-> $past(vsync_evt);
	endproperty
	a_frame_apply: assert property (p_frame_apply) // RQ21
		else $error("configuration changed mid frame");

	c_wide_frame: cover property (@(posedge clk) disable iff (!rst_n)
		seq_r == lpm_pkg::SEQ_BOTTOM && gate_group_pulse);
	c_duty_max: cover property (@(posedge clk) disable iff (!rst_n)
		at_max && boost_gate_drive);
	c_serial_write: cover property (@(posedge clk) disable iff (!rst_n)
		wr_fmt ##[1:1000] vsync_evt);
endmodule

//--- rtl/lpm_serial_rx.sv
// three-wire serial word receiver, msb first, latched on select release
`timescale 1ns/10ps
module lpm_serial_rx (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// serial pins
	input  wire logic        scl,
	input  wire logic        sda,
	input  wire logic        cs_n,
	// register write
	output logic             wr_stb,
	output logic [2:0]       wr_addr,
	output logic [12:0]      wr_data
);
	logic        scl_q_r;
	logic        cs_q_r;
	logic [15:0] shift_r;
	logic [4:0]  cnt_r;
	logic        stb_r;
	logic [15:0] word_r;

	wire scl_rise = scl && !scl_q_r && !cs_n;
	wire cs_rise  = cs_n && !cs_q_r;
	// words of any other length are dropped whole
	wire take     = cs_rise && (cnt_r == lpm_pkg::WORD_COUNT);
	wire [4:0] cnt_nxt = cs_n ? 5'h00 :
		(scl_rise && cnt_r != lpm_pkg::COUNT_SAT) ? cnt_r + 5'h01 : cnt_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			scl_q_r <= 1'b0;
			cs_q_r  <= 1'b1;
			shift_r <= 16'h0000;
			cnt_r   <= 5'h00;
			stb_r   <= 1'b0;
			word_r  <= 16'h0000;
		end else begin
			scl_q_r <= scl;
			cs_q_r  <= cs_n;
			if (scl_rise)
				shift_r <= {shift_r[14:0], sda};
			cnt_r <= cnt_nxt;
			stb_r <= take;
			if (take)
				word_r <= shift_r;
		end
	end

	assign wr_stb  = stb_r;
	assign wr_addr = word_r[15:13];
	assign wr_data = word_r[12:0];
endmodule
